/* File: hw/vfd_cmd_regs.vh */
// constants for the serial command and key scan front end
`ifndef VFD_CMD_REGS_VH
`define VFD_CMD_REGS_VH
// command byte class field
`define CMD_CLASS_HI      7
`define CMD_CLASS_LO      6
`define CLASS_MODE        2'h0
`define CLASS_DATA        2'h1
// data setting sub-selects
`define DSET_LED          2'h1
`define DSET_KEYRD        2'h2
// reset values
`define MODE_RESET        3'h7
`define LED_RESET         4'h0
// timing: one slot is 224 oscillator periods
`define SLOT_OSC_PERIODS  224
`define OSC_PERIOD_NS     2000
`define CLK_PERIOD_NS     10
`endif

/* File: hw/key_store_mem.v */
// key data storage, four bytes with registered read
`timescale 1ns/1ps
module key_store_mem #(
	parameter AW = 2,
	parameter DW = 8
) (
	input  wire          sys_clk_i,  // core clock
	input  wire          clk_en_i,   // freeze when low
	input  wire          wr_en_i,    // write strobe
	input  wire [AW-1:0] wr_addr_i,  // write address
	input  wire [DW-1:0] wr_data_i,  // write data
	input  wire [AW-1:0] rd_addr_i,  // read address
	output reg  [DW-1:0] rd_data_o   // registered read data
);
	reg [DW-1:0] mem_r [0:(1<<AW)-1];  // storage words

	// write and registered read
	always @(posedge sys_clk_i) begin
		if (clk_en_i) begin
			if (wr_en_i) begin
				mem_r[wr_addr_i] <= wr_data_i;
			end
			rd_data_o <= mem_r[rd_addr_i];
		end
	end
endmodule // key_store_mem

/* File: hw/vfd_serial_command_keyscan.v */
// serial command front end with display scan and key matrix capture
`timescale 1ns/1ps
`include "vfd_cmd_regs.vh"
module vfd_serial_command_keyscan #(
	parameter SLOT_CYCLES = `SLOT_OSC_PERIODS * `OSC_PERIOD_NS / `CLK_PERIOD_NS,
	parameter SLOT_W      = 16
) (
	input  wire        sys_clk_i,                // core clock
	input  wire        rst_i,                    // synchronous reset
	input  wire        clk_en_i,                 // freezes all state when low
	input  wire        frame_strobe_i,           // serial strobe pin
	input  wire        shift_clk_i,              // serial shift clock pin
	input  wire        serial_din_i,             // serial data in pin
	output wire        serial_dout_o,            // open-drain data out level
	output reg         serial_dout_oe_o,         // high while pulling low
	input  wire        key_return_1_i,           // key return line 1
	input  wire        key_return_2_i,           // key return line 2
	input  wire [23:0] seg_data_i,               // segment pattern for current grid
	input  wire        display_on_set_i,         // pulse: display control turns on
	output reg  [15:0] segment_keysource_o,      // segment / key source lines
	output reg  [7:0]  shared_seg_grid_o,        // shared segment/grid lines
	output reg  [3:0]  grid_line_o,              // dedicated grid lines
	output reg  [3:0]  lamp_port_o,              // lamp ports, low lights lamp
	output reg  [2:0]  display_mode_o,           // current display mode
	output reg         display_on_o,             // display running
	output reg  [3:0]  grid_index_o,             // low four bits of slot in drive, 0 based
	output reg  [7:0]  cmd_byte_o,               // last command byte
	output reg         cmd_valid_o,              // pulse with cmd_byte_o
	output reg  [7:0]  data_byte_o,              // last data byte
	output reg         data_valid_o              // pulse with data_byte_o
);
	////////////////////////////////////////////////////////////////////////
	// functions
	// grids used by a mode
	function [4:0] grids_of;
		input [2:0] mode;
		begin
			if (mode == 3'h7) begin
				grids_of = 5'h0C;
			end else begin
				grids_of = {2'h0, mode} + 5'h04;
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	reg [1:0] stb_sync_r;   // strobe two-stage
	reg [1:0] sck_sync_r;   // shift clock two-stage
	reg [1:0] din_sync_r;   // data in two-stage
	reg [1:0] k1_sync_r;    // key return 1 two-stage
	reg [1:0] k2_sync_r;    // key return 2 two-stage
	reg       sck_prev_r;   // delayed shift clock for edges
	wire      stb_s  = stb_sync_r[1];
	wire      sck_s  = sck_sync_r[1];
	wire      sck_rise = sck_s & ~sck_prev_r;
	wire      sck_fall = ~sck_s & sck_prev_r;

	// two flops per pin before any logic
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			stb_sync_r <= 2'h3;
			sck_sync_r <= 2'h3;
			din_sync_r <= 2'h0;
			k1_sync_r  <= 2'h0;
			k2_sync_r  <= 2'h0;
			sck_prev_r <= 1'b1;
		end else if (clk_en_i) begin
			stb_sync_r <= {stb_sync_r[0], frame_strobe_i};
			sck_sync_r <= {sck_sync_r[0], shift_clk_i};
			din_sync_r <= {din_sync_r[0], serial_din_i};
			k1_sync_r  <= {k1_sync_r[0], key_return_1_i};
			k2_sync_r  <= {k2_sync_r[0], key_return_2_i};
			sck_prev_r <= sck_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// serial receiver and command decode
	reg [7:0] shift_r;      // incoming byte
	reg [2:0] bit_cnt_r;    // bits received in byte
	reg       first_r;      // next byte is a command
	reg       led_wr_r;     // data bytes go to lamp ports
	reg       key_rd_r;     // falling edges shift key data out
	reg [2:0] rd_bit_r;     // read bit pointer
	reg [1:0] rd_byte_r;    // read byte pointer
	reg       dout_bit_r;   // current read bit
	reg       disp_off_req; // mode change seen this cycle
	wire [7:0] rx_byte = {din_sync_r[1], shift_r[7:1]};
	wire       byte_done = sck_rise & ~stb_s & (bit_cnt_r == 3'h7);
	wire [1:0] rx_class = rx_byte[`CMD_CLASS_HI:`CMD_CLASS_LO];
	wire [7:0] key_q;       // stored key byte

	// open drain: release for one, pull low for zero
	assign serial_dout_o = 1'b0;

	// shift in, count bits, decode bytes
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			shift_r        <= 8'h00;
			bit_cnt_r      <= 3'h0;
			first_r        <= 1'b1;
			led_wr_r       <= 1'b0;
			key_rd_r       <= 1'b0;
			cmd_byte_o     <= 8'h00;
			cmd_valid_o    <= 1'b0;
			data_byte_o    <= 8'h00;
			data_valid_o   <= 1'b0;
			display_mode_o <= `MODE_RESET;
			lamp_port_o    <= `LED_RESET;
			disp_off_req   <= 1'b0;
		end else if (clk_en_i) begin
			cmd_valid_o  <= 1'b0;
			data_valid_o <= 1'b0;
			disp_off_req <= 1'b0;
			if (stb_s) begin
				// strobe high: drop partial byte, rearm for a command
				bit_cnt_r <= 3'h0;
				first_r   <= 1'b1;
				key_rd_r  <= 1'b0;
			end else if (sck_rise) begin
				shift_r   <= rx_byte;
				bit_cnt_r <= bit_cnt_r + 3'h1;
			end
			if (byte_done) begin
				first_r <= 1'b0;
				if (first_r) begin
					// command byte
					cmd_byte_o  <= rx_byte;
					cmd_valid_o <= 1'b1;
					led_wr_r    <= 1'b0;
					if (rx_class == `CLASS_MODE) begin
						// low three bits pick the mode, b5..b3 ignored
						if (rx_byte[2:0] != display_mode_o) begin
							display_mode_o <= rx_byte[2:0];
							disp_off_req   <= 1'b1;
						end
					end else if (rx_class == `CLASS_DATA) begin
						led_wr_r <= (rx_byte[1:0] == `DSET_LED);
						key_rd_r <= (rx_byte[1:0] == `DSET_KEYRD);
					end
				end else begin
					// data byte for the current command
					data_byte_o  <= rx_byte;
					data_valid_o <= 1'b1;
					if (led_wr_r) begin
						lamp_port_o <= rx_byte[3:0];
					end
				end
			end
		end
	end

	// key data shifted out on falling edges
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			rd_bit_r         <= 3'h0;
			rd_byte_r        <= 2'h0;
			dout_bit_r       <= 1'b1;
			serial_dout_oe_o <= 1'b0;
		end else if (clk_en_i) begin
			if (stb_s | ~key_rd_r) begin
				// idle: pin released, pointers home
				rd_bit_r         <= 3'h0;
				rd_byte_r        <= 2'h0;
				dout_bit_r       <= 1'b1;
				serial_dout_oe_o <= 1'b0;
			end else if (sck_fall) begin
				dout_bit_r       <= key_q[rd_bit_r];
				serial_dout_oe_o <= ~key_q[rd_bit_r];
				rd_bit_r         <= rd_bit_r + 3'h1;
				if (rd_bit_r == 3'h7) begin
					rd_byte_r <= rd_byte_r + 2'h1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// display and key scan timing
	reg [SLOT_W-1:0] slot_cnt_r;  // cycles within slot
	reg [4:0]        pos_r;       // slot within frame
	reg              half_r;      // second frame of key cycle
	reg [31:0]       stage_r;     // key levels of this cycle
	reg [2:0]        commit_r;    // bytes left to commit
	wire [4:0]       grids     = grids_of(display_mode_o);
	wire             slot_end  = (slot_cnt_r == SLOT_CYCLES - 1);
	wire             in_keys   = (pos_r >= grids);
	wire [4:0]       ks_off    = pos_r - grids;
	wire [3:0]       ks_idx    = {half_r, ks_off[2:0]};
	wire             frame_end = slot_end & (pos_r == grids + 5'h07);
	wire [1:0]       wr_addr   = commit_r[1:0] - 2'h1;

	// slot, frame and key cycle counters
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			slot_cnt_r   <= {SLOT_W{1'b0}};
			pos_r        <= 5'h00;
			half_r       <= 1'b0;
			display_on_o <= 1'b0;
		end else if (clk_en_i) begin
			if (disp_off_req) begin
				// mode change stops display and scan, restarts frame
				display_on_o <= 1'b0;
				slot_cnt_r   <= {SLOT_W{1'b0}};
				pos_r        <= 5'h00;
				half_r       <= 1'b0;
			end else begin
				if (display_on_set_i) begin
					display_on_o <= 1'b1;
				end
				if (display_on_o) begin
					if (slot_end) begin
						slot_cnt_r <= {SLOT_W{1'b0}};
						if (frame_end) begin
							pos_r  <= 5'h00;
							half_r <= ~half_r;
						end else begin
							pos_r <= pos_r + 5'h01;
						end
					end else begin
						slot_cnt_r <= slot_cnt_r + {{(SLOT_W-1){1'b0}}, 1'b1};
					end
				end
			end
		end
	end

	// key level capture and commit to storage
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			stage_r  <= 32'h0000_0000;
			commit_r <= 3'h0;
		end else if (clk_en_i) begin
			if (commit_r != 3'h0) begin
				commit_r <= commit_r - 3'h1;
			end
			if (display_on_o & ~disp_off_req & slot_end & in_keys) begin
				stage_r[{ks_idx, 1'b0}] <= k1_sync_r[1];
				stage_r[{ks_idx, 1'b1}] <= k2_sync_r[1];
				if (frame_end & half_r) begin
					commit_r <= 3'h4;
				end
			end
		end
	end

	// storage write data: one byte per commit cycle
	reg [7:0] wr_data;
	always @* begin
		case (wr_addr)
			2'h0:    wr_data = stage_r[7:0];
			2'h1:    wr_data = stage_r[15:8];
			2'h2:    wr_data = stage_r[23:16];
			default: wr_data = stage_r[31:24];
		endcase
	end

	// key data storage
	key_store_mem #(
		.AW (2),
		.DW (8)
	) u_key_store (
		.sys_clk_i (sys_clk_i),
		.clk_en_i  (clk_en_i),
		.wr_en_i   (commit_r != 3'h0),
		.wr_addr_i (wr_addr),
		.wr_data_i (wr_data),
		.rd_addr_i (rd_byte_r),
		.rd_data_o (key_q)
	);

	////////////////////////////////////////////////////////////////////////
	// output drivers
	integer i;
	// grid select, segment data and key source drive
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			segment_keysource_o <= 16'h0000;
			shared_seg_grid_o   <= 8'h00;
			grid_line_o         <= 4'h0;
			grid_index_o        <= 4'h0;
		end else if (clk_en_i) begin
			segment_keysource_o <= 16'h0000;
			shared_seg_grid_o   <= 8'h00;
			grid_line_o         <= 4'h0;
			grid_index_o        <= pos_r[3:0];
			if (display_on_o & ~disp_off_req) begin
				if (in_keys) begin
					// one key source high, grids dark
					segment_keysource_o[ks_idx] <= 1'b1;
				end else begin
					segment_keysource_o <= seg_data_i[15:0];
					for (i = 0; i < 8; i = i + 1) begin
						// shared pin i is grid 12-i when enough grids
						if (i >= 12 - grids) begin
							shared_seg_grid_o[i] <= (pos_r == 5'h0B - i[4:0]);
						end else begin
							shared_seg_grid_o[i] <= seg_data_i[16 + i];
						end
					end
					if (pos_r < 5'h04) begin
						grid_line_o[pos_r[1:0]] <= 1'b1;
					end
				end
			end
		end
	end
endmodule // vfd_serial_command_keyscan

/* File: sim/vfd_cmd_chk.sv */
// port assertions for the serial command and key scan front end
`timescale 1ns/1ps
module vfd_cmd_chk (
	input wire       sys_clk_i,        // core clock
	input wire       rst_i,            // synchronous reset
	input wire       frame_strobe_i,   // strobe pin
	input wire       shift_clk_i,      // shift clock pin
	input wire       serial_dout_oe_o, // pull-low enable
	input wire [3:0] grid_line_o,      // dedicated grids
	input wire [3:0] lamp_port_o,      // lamp ports
	input wire [2:0] display_mode_o,   // current mode
	input wire       display_on_o,     // display running
	input wire [7:0] cmd_byte_o,       // command byte
	input wire       cmd_valid_o,      // command pulse
	input wire [7:0] data_byte_o,      // data byte
	input wire       data_valid_o      // data pulse
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	//////////////////////////////////////////////////////////////////
	// mode command arriving with a mode other than the one in force before it
	sequence new_mode_s;
		cmd_valid_o && cmd_byte_o[7:6] == 2'h0 && cmd_byte_o[2:0] != $past(display_mode_o);
	endsequence
	// mode command repeating the mode already in force
	sequence same_mode_s;
		cmd_valid_o && cmd_byte_o[7:6] == 2'h0 && cmd_byte_o[2:0] == $past(display_mode_o);
	endsequence
	// mode taken with the command pulse, display dark one cycle later
	sequence mode_applied_s;
		display_mode_o == cmd_byte_o[2:0] ##1 !display_on_o;
	endsequence
	// link idle long enough for the synchronisers
	sequence idle_s;
		frame_strobe_i [*6];
	endsequence
	//////////////////////////////////////////////////////////////////
	a_mode_reset: assert property ($fell(rst_i) |-> display_mode_o == 3'h7)
		else $error("mode after reset wrong");
	a_lamp_reset: assert property ($fell(rst_i) |-> lamp_port_o == 4'h0)
		else $error("lamps after reset wrong");
	a_mode_change: assert property (new_mode_s |-> mode_applied_s)
		else $error("mode change not applied");
	a_mode_same: assert property (same_mode_s |=> !$fell(display_on_o))
		else $error("repeated mode turned display off");
	a_mode_cause: assert property ($changed(display_mode_o) |-> cmd_valid_o
		&& cmd_byte_o[7:6] == 2'h0)
		else $error("mode changed without mode command");
	a_valid_pulse: assert property (cmd_valid_o |=> !cmd_valid_o && !data_valid_o)
		else $error("byte pulse too long");
	a_strobe_quiet: assert property (idle_s |-> !cmd_valid_o && !data_valid_o
		&& !serial_dout_oe_o)
		else $error("activity while strobe high");
	a_lamp_write: assert property ($changed(lamp_port_o) |-> data_valid_o
		&& lamp_port_o == data_byte_o[3:0])
		else $error("lamp change without data");
	a_dout_fall: assert property ($changed(serial_dout_oe_o) && !frame_strobe_i
		|-> !shift_clk_i)
		else $error("data out moved off falling edge");
	a_grid_single: assert property ($onehot0(grid_line_o))
		else $error("several grids driven");
endmodule // vfd_cmd_chk
bind vfd_serial_command_keyscan vfd_cmd_chk u_vfd_cmd_chk (
	.sys_clk_i(sys_clk_i), .rst_i(rst_i), .frame_strobe_i(frame_strobe_i),
	.shift_clk_i(shift_clk_i), .serial_dout_oe_o(serial_dout_oe_o),
	.grid_line_o(grid_line_o), .lamp_port_o(lamp_port_o), .display_mode_o(display_mode_o),
	.display_on_o(display_on_o), .cmd_byte_o(cmd_byte_o), .cmd_valid_o(cmd_valid_o),
	.data_byte_o(data_byte_o), .data_valid_o(data_valid_o)
);

/* File: sim/host_link_model.sv */
// host side model of the three-wire serial link
`timescale 1ns/1ps
module host_link_model (
	output logic frame_strobe_o, // strobe, high = idle
	output logic shift_clk_o,    // shift clock, idles high
	output logic serial_din_o,   // data towards device
	input  wire  dout_line_i     // pulled-up device data
);
	initial begin
		frame_strobe_o = 1'b1;
		shift_clk_o = 1'b1;
		serial_din_o = 1'b1;
	end
	// open a frame after an off-edge delay
	task automatic frame_open;
		#301 frame_strobe_o = 1'b0;
		#1000;
	endtask
	// close with clock-to-strobe gap, then invert the stale data bit
	task automatic frame_close;
		#1000 frame_strobe_o = 1'b1;
		serial_din_o = ~serial_din_o;
		#1000;
	endtask
	// n bits lsb first, device bits collected at each rise
	task automatic shift(input logic [7:0] d, input int n, output logic [7:0] q);
		q = 8'h00;
		for (int i = 0; i < n; i++) begin
			shift_clk_o = 1'b0;
			serial_din_o = d[i];
			#80 shift_clk_o = 1'b1;
			q[i] = dout_line_i;
			#80;
		end
		#1000;
	endtask
endmodule // host_link_model

/* File: sim/vfd_serial_command_keyscan_test.sv */
// self-checking bench for the serial command and key scan front end
`timescale 1ns/1ps
`define CHECK(got, exp) begin \
	checks++; \
	if ((got) !== (exp)) begin \
		err_count++; \
		$display("unexpected at %0t: got %0h expected %0h", $time, got, exp); \
	end \
end
module vfd_serial_command_keyscan_test;
	logic        sys_clk_i, rst_i, display_on_set_i; // core side drives
	logic        key_return_1_i, key_return_2_i;     // key lines
	logic [7:0]  rd_q;                               // last byte read back
	logic [7:0]  slot_len;                           // measured slot length in cycles
	int          err_count, checks;                  // tallies
	wire         frame_strobe_i, shift_clk_i, serial_din_i, serial_dout_o, serial_dout_oe_o;
	wire         display_on_o, cmd_valid_o, data_valid_o;
	wire [15:0]  segment_keysource_o;
	wire [7:0]   shared_seg_grid_o, cmd_byte_o, data_byte_o;
	wire [3:0]   grid_line_o, lamp_port_o, grid_index_o;
	wire [2:0]   display_mode_o;
	wire         dout_line = serial_dout_oe_o ? serial_dout_o : 1'b1; // pull-up
	vfd_serial_command_keyscan #(.SLOT_CYCLES(20)) u_vfd_serial_command_keyscan (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(1'b1),
		.frame_strobe_i(frame_strobe_i), .shift_clk_i(shift_clk_i),
		.serial_din_i(serial_din_i), .serial_dout_o(serial_dout_o),
		.serial_dout_oe_o(serial_dout_oe_o), .key_return_1_i(key_return_1_i),
		.key_return_2_i(key_return_2_i), .seg_data_i(24'h0F00F0),
		.display_on_set_i(display_on_set_i), .segment_keysource_o(segment_keysource_o),
		.shared_seg_grid_o(shared_seg_grid_o), .grid_line_o(grid_line_o),
		.lamp_port_o(lamp_port_o), .display_mode_o(display_mode_o),
		.display_on_o(display_on_o), .grid_index_o(grid_index_o),
		.cmd_byte_o(cmd_byte_o), .cmd_valid_o(cmd_valid_o),
		.data_byte_o(data_byte_o), .data_valid_o(data_valid_o)
	);
	host_link_model u_host_link_model (
		.frame_strobe_o(frame_strobe_i), .shift_clk_o(shift_clk_i),
		.serial_din_o(serial_din_i), .dout_line_i(dout_line)
	);
	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	//////////////////////////////////////////////////////////////////
	// counts, verdict and end of run
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// one frame: command plus optional data byte, read bits land in rd_q
	task automatic xfer(input logic [7:0] c, input logic [7:0] d, input bit has_d);
		u_host_link_model.frame_open();
		u_host_link_model.shift(c, 8, rd_q);
		if (has_d) u_host_link_model.shift(d, 8, rd_q);
		u_host_link_model.frame_close();
	endtask
	// display control stand-in
	task automatic pulse_on;
		@(posedge sys_clk_i) display_on_set_i <= 1'b1;
		@(posedge sys_clk_i) display_on_set_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
	endtask
	// bounded wait for the last key source, then for storage commit
	task automatic wait_scan;
		int n;
		n = 0;
		while (segment_keysource_o !== 16'h8000 && n < 9000) begin
			@(posedge sys_clk_i);
			n++;
		end
		repeat (100) @(posedge sys_clk_i);
		if (n >= 9000) begin
			err_count++;
			wrap_up();
		end
	endtask
	// bounded wait until the given slot is shown, sampled at falling clock edges
	task automatic wait_grid(input logic [3:0] g);
		int n;
		n = 0;
		while (grid_index_o !== g && n < 2000) begin
			@(negedge sys_clk_i);
			n++;
		end
		if (n >= 2000) begin
			err_count++;
			wrap_up();
		end
	endtask
	//////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		rst_i = 1'b1;
		display_on_set_i = 1'b0;
		key_return_1_i = 1'b1;
		key_return_2_i = 1'b0;
		err_count = 0;
		checks = 0;
		repeat (10) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		repeat (5) @(posedge sys_clk_i);
		`CHECK(display_mode_o, 3'h7)
		`CHECK(lamp_port_o, 4'h0)
		xfer(8'h41, 8'hA5, 1);
		`CHECK(lamp_port_o, 4'h5)
		`CHECK(data_byte_o, 8'hA5)
		`CHECK(cmd_byte_o, 8'h41)
		$display("lamp test finished");
		u_host_link_model.shift(8'h00, 8, rd_q); // clocks while strobe high
		u_host_link_model.frame_open();
		u_host_link_model.shift(8'h00, 4, rd_q); // half byte then abort
		u_host_link_model.frame_close();
		`CHECK(cmd_byte_o, 8'h41)
		xfer(8'h33, 8'h00, 0);
		`CHECK(cmd_byte_o, 8'h33)
		`CHECK(display_mode_o, 3'h3)
		$display("strobe test finished");
		pulse_on();
		xfer(8'h03, 8'h00, 0);
		`CHECK(display_on_o, 1'b1)
		xfer(8'h05, 8'h00, 0);
		`CHECK({display_mode_o, display_on_o}, 4'hA)
		$display("mode test finished");
		pulse_on();
		wait_scan();
		xfer(8'h42, 8'hFF, 1);
		`CHECK(rd_q, 8'h55)
		`CHECK(serial_dout_oe_o, 1'b0)
		`CHECK(lamp_port_o, 4'h5)
		$display("key test finished");
		// mode 5: nine grids, shared pins 0..2 are segments 17..19
		wait_grid(4'h1);
		`CHECK(grid_line_o, 4'h2)
		`CHECK(segment_keysource_o, 16'h00F0)
		`CHECK(shared_seg_grid_o, 8'h07)
		wait_grid(4'h5);
		`CHECK(grid_line_o, 4'h0)
		`CHECK(shared_seg_grid_o, 8'h47)
		wait_grid(4'h6);
		slot_len = 8'h00;
		while (grid_index_o === 4'h6 && slot_len < 8'h64) begin
			@(negedge sys_clk_i);
			slot_len++;
		end
		`CHECK(slot_len, 8'h14)
		wait_grid(4'h9);
		`CHECK($countones(segment_keysource_o), 1)
		`CHECK(segment_keysource_o & 16'hFEFE, 16'h0000)
		`CHECK({grid_line_o, shared_seg_grid_o}, 12'h000)
		$display("scan test finished");
		wrap_up();
	end
endmodule // vfd_serial_command_keyscan_test
